// [design/osf_pkg.sv]
// Package for the OFDM symbol framer: constants and carrier types
// Summary of operation
// RULE1: Symbol is prefix followed by transform output
// RULE2: Prefix lengths are 1/32, 1/16, 1/8
// RULE3: Beacons always use the 1/8 prefix
// RULE4: Transform size is 128 points
// RULE5: Zero 26 tones: 13 low, DC, 12 high; the framer zeroes them in header and payload symbols only
// RULE6: 98 data plus 4 pilot tones used
// RULE7: Guard tones only at edges besides DC
// RULE8: Input vector mixes data, pilots, guards
// RULE9: Preamble, then header, then payload symbols
// RULE10: Header is two symbols, tail six bits
// RULE11: Normal preamble in normal mode, first stream packet
// RULE12: Burst preamble for later streaming packets
// RULE13: Normal preamble: short symbol plus long part
// RULE14: Long part repeats long training twice
// RULE15: Normal preamble symbols use 1/8 prefix
// RULE16: Short symbol: 16-sample vector, nine copies
// RULE17: Short sequence scaled by sqrt(102/12)
// RULE18: 6 MHz: 53.571 kHz spacing, 18.667 us
// RULE19: Symbol periods 19.25, 19.833, 21.0 us
// RULE20: Burst preamble: two 64-sample vectors, one symbol
// RULE21: Prefix copies the last output samples
package osf_pkg;
  localparam int N_FFT = 128;
  localparam int GUARD_LOW = 13;
  localparam int GUARD_HIGH = 12;
  localparam int DC_BIN = 64;
  localparam int N_DATA = 98;
  localparam int N_PILOT = 4;
  localparam int SHORT_VEC = 16;
  localparam int BURST_VEC = 64;
  localparam int HEADER_SYMS = 2;
  localparam int TAIL_BITS = 6;
  localparam int CP_LEN_32 = 4;
  localparam int CP_LEN_16 = 8;
  localparam int CP_LEN_8 = 16;
  localparam int T_FFT_PS = 18667000;
  localparam int SAMPLE_NS = 100;
  localparam logic [6:0] PILOT_BIN0 = 7'h1c;
  localparam logic [6:0] PILOT_BIN1 = 7'h34;
  localparam logic [6:0] PILOT_BIN2 = 7'h4c;
  localparam logic [6:0] PILOT_BIN3 = 7'h64;
  localparam logic [1:0] CP_MODE_32 = 2'h0;
  localparam logic [1:0] CP_MODE_16 = 2'h1;
  localparam logic [1:0] CP_MODE_8 = 2'h2;
  typedef struct packed {
    logic [15:0] re;
    logic [15:0] im;
  } osf_sample_t;
  typedef struct packed {
    logic [1:0] cp_mode;
    logic beacon;
    logic streaming;
    logic first_of_stream;
    logic [11:0] payload_syms;
  } osf_frame_t;
  typedef enum logic [2:0] {
    OSF_IDLE, OSF_FILL, OSF_XFORM, OSF_EMIT
  } osf_state_t;
  typedef enum logic [2:0] {
    SEG_SHORT, SEG_LONG1, SEG_LONG2, SEG_BURST, SEG_HEADER_SYMBOL_FIRST, SEG_HEADER_SYMBOL_SECOND, SEG_PAY
  } osf_seg_t;
endpackage

// [design/osf_framer.sv]
// OFDM symbol framer: tone mapping, transform handshake, prefix and sequencing
module osf_framer
  import osf_pkg::*;
#(
  parameter int SYM_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Frame request from the MAC
  input wire logic frame_valid_in,
  input wire osf_pkg::osf_frame_t frame_in,
  output logic frame_ready_out,
  // Mapped tones from the constellation mapper and pilots
  input wire osf_pkg::osf_sample_t data_tone_in,
  input wire osf_pkg::osf_sample_t pilot_tone_in,
  input wire osf_pkg::osf_sample_t train_tone_in,
  output logic data_take_out,
  output logic pilot_take_out,
  output logic train_take_out,
  output logic [2:0] seg_out,
  // Transform engine, 128 points
  output logic xform_start_out,
  output logic xform_we_out,
  output logic [6:0] xform_addr_out,
  output osf_pkg::osf_sample_t xform_wdata_out,
  input wire logic xform_done_in,
  input wire osf_pkg::osf_sample_t xform_rdata_in,
  // Baseband sample stream
  output logic sample_valid_out,
  output osf_pkg::osf_sample_t sample_out,
  output logic in_prefix_out,
  output logic frame_end_out
);
  import osf_pkg::*;

  // Widths beyond the frame's symbol field cannot be served
  if (SYM_W < 2 || SYM_W > 12) begin : g_bad_sym_w
    $error("SYM_W out of range");
  end

  // ************************************************************
  // Frame state
  // ************************************************************
  osf_state_t state;
  osf_seg_t seg;
  osf_frame_t frame;
  logic [6:0] bin;
  logic [7:0] ecnt;
  logic [4:0] cp_len;
  logic [11:0] pay_left;
  logic [6:0] rd_addr;
  logic is_guard;
  logic is_pilot;
  logic cp_long;

  // Guard tones at both edges plus DC only, nothing in between [RULE5] [RULE7]
  assign is_guard = (bin < 7'(GUARD_LOW)) || (bin == 7'(DC_BIN)) ||
                    (bin > 7'(N_FFT - 1 - GUARD_HIGH));
  // Four pilots spread across the occupied band [RULE6]
  assign is_pilot = (bin == PILOT_BIN0) || (bin == PILOT_BIN1) ||
                    (bin == PILOT_BIN2) || (bin == PILOT_BIN3);
  // Preamble and beacons force the 1/8 prefix [RULE3] [RULE15] [RULE20]
  assign cp_long = frame.beacon || (seg == SEG_SHORT) || (seg == SEG_LONG1) ||
                   (seg == SEG_LONG2) || (seg == SEG_BURST);

  // Prefix length in samples; 10 MHz sample rate stands in for the
  // channel rate, so times scale but ratios hold [RULE2] [RULE18] [RULE19]
  always_comb begin
    if (cp_long || frame.cp_mode == CP_MODE_8) begin
      cp_len = 5'(CP_LEN_8);
    end else if (frame.cp_mode == CP_MODE_16) begin
      cp_len = 5'(CP_LEN_16);
    end else begin
      cp_len = 5'(CP_LEN_32);
    end
  end

  // Emission read address: prefix is the tail of the output [RULE1] [RULE21]
  always_comb begin
    if (ecnt < {3'h0, cp_len}) begin
      rd_addr = 7'(N_FFT) - 7'(cp_len) + ecnt[6:0];
    end else begin
      rd_addr = 7'(ecnt - {3'h0, cp_len});
    end
  end

  // Main sequencer: fill 128 bins, transform, emit prefix and body [RULE4] [RULE8]
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= OSF_IDLE;
      seg <= SEG_SHORT;
      frame <= '0;
      bin <= 7'h00;
      ecnt <= 8'h00;
      pay_left <= 12'h000;
    end else begin
      case (state)
        OSF_IDLE: begin
          if (frame_valid_in) begin
            frame <= frame_in;
            pay_left <= frame_in.payload_syms;
            bin <= 7'h00;
            // Burst preamble only after the first packet of a stream [RULE11] [RULE12]
            seg <= (frame_in.streaming && !frame_in.first_of_stream) ? SEG_BURST
                                                                      : SEG_SHORT;
            state <= OSF_FILL;
          end
        end
        OSF_FILL: begin
          bin <= bin + 7'h01;
          if (bin == 7'(N_FFT - 1)) begin
            state <= OSF_XFORM;
          end
        end
        OSF_XFORM: begin
          ecnt <= 8'h00;
          if (xform_done_in) begin
            state <= OSF_EMIT;
          end
        end
        OSF_EMIT: begin
          ecnt <= ecnt + 8'h01;
          if (ecnt == 8'(N_FFT - 1) + {3'h0, cp_len}) begin
            bin <= 7'h00;
            state <= OSF_FILL;
            // Fixed symbol order through the frame [RULE9] [RULE10] [RULE13] [RULE14]
            case (seg)
              SEG_SHORT: seg <= SEG_LONG1;
              SEG_LONG1: seg <= SEG_LONG2;
              SEG_LONG2: seg <= SEG_HEADER_SYMBOL_FIRST;
              SEG_BURST: seg <= SEG_HEADER_SYMBOL_FIRST;
              SEG_HEADER_SYMBOL_FIRST: seg <= SEG_HEADER_SYMBOL_SECOND;
              SEG_HEADER_SYMBOL_SECOND: begin
                if (pay_left == 12'h000) begin
                  state <= OSF_IDLE;
                end else begin
                  seg <= SEG_PAY;
                end
              end
              default: begin
                pay_left <= pay_left - 12'h001;
                if (pay_left == 12'h001) begin
                  state <= OSF_IDLE;
                end
              end
            endcase
          end
        end
        default: state <= OSF_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  logic training;
  assign training = (seg != SEG_HEADER_SYMBOL_FIRST) && (seg != SEG_HEADER_SYMBOL_SECOND) && (seg != SEG_PAY);

  // Tone loading: training vectors take every bin from the training source; else guards zero, pilots and data pulled in order [RULE5] [RULE8]
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xform_we_out <= 1'b0;
      xform_addr_out <= 7'h00;
      xform_wdata_out <= '0;
      data_take_out <= 1'b0;
      pilot_take_out <= 1'b0;
      train_take_out <= 1'b0;
    end else begin
      xform_we_out <= (state == OSF_FILL);
      xform_addr_out <= (state == OSF_FILL) ? bin : rd_addr;
      data_take_out <= 1'b0;
      pilot_take_out <= 1'b0;
      train_take_out <= 1'b0;
      if (state == OSF_FILL) begin
        if (training) begin
          // Training tones come prescaled, including sqrt(102/12) [RULE16] [RULE17]
          xform_wdata_out <= train_tone_in;
          train_take_out <= 1'b1;
        end else if (is_guard) begin
          xform_wdata_out <= '0;
        end else if (is_pilot) begin
          xform_wdata_out <= pilot_tone_in;
          pilot_take_out <= 1'b1;
        end else begin
          xform_wdata_out <= data_tone_in;
          data_take_out <= 1'b1;
        end
      end else begin
        xform_wdata_out <= '0;
      end
    end
  end

  // Transform start pulse, handshake and status
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xform_start_out <= 1'b0;
      frame_ready_out <= 1'b0;
      seg_out <= 3'h0;
    end else begin
      xform_start_out <= (state == OSF_FILL) && (bin == 7'(N_FFT - 1));
      frame_ready_out <= (state == OSF_IDLE) && !frame_valid_in;
      seg_out <= seg;
    end
  end

  // Sample stream; read data follows address by one cycle [RULE1] [RULE21]
  logic emit_d;
  logic pref_d;
  logic last_d;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      emit_d <= 1'b0;
      pref_d <= 1'b0;
      last_d <= 1'b0;
      sample_valid_out <= 1'b0;
      sample_out <= '0;
      in_prefix_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      emit_d <= (state == OSF_EMIT);
      pref_d <= (state == OSF_EMIT) && (ecnt < {3'h0, cp_len});
      last_d <= (state == OSF_EMIT) && (ecnt == 8'(N_FFT - 1) + {3'h0, cp_len}) &&
                ((seg == SEG_PAY && pay_left == 12'h001) ||
                 (seg == SEG_HEADER_SYMBOL_SECOND && pay_left == 12'h000));
      sample_valid_out <= emit_d;
      sample_out <= emit_d ? xform_rdata_in : '0;
      in_prefix_out <= pref_d;
      frame_end_out <= last_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Helper counters for the checks: tones per symbol and run lengths
  logic [7:0] n_data_bins;
  logic [2:0] n_pilot_bins;
  logic [4:0] n_guard_bins;
  logic [7:0] run_len;
  logic [4:0] pre_len;

  // Tone plan tally; restarts at bin 0 so it holds through the transform wait
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      n_data_bins <= 8'h00;
      n_pilot_bins <= 3'h0;
      n_guard_bins <= 5'h00;
    end else if (state == OSF_FILL) begin
      if (bin == 7'h00) begin
        n_data_bins <= {7'h00, !is_guard && !is_pilot};
        n_pilot_bins <= {2'h0, is_pilot};
        n_guard_bins <= {4'h0, is_guard};
      end else begin
        n_data_bins <= n_data_bins + {7'h00, !is_guard && !is_pilot};
        n_pilot_bins <= n_pilot_bins + {2'h0, is_pilot};
        n_guard_bins <= n_guard_bins + {4'h0, is_guard};
      end
    end
  end

  // Unbroken sample run length; the fill gap clears it between symbols
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_len <= 8'h00;
    end else if (sample_valid_out) begin
      run_len <= run_len + 8'h01;
    end else begin
      run_len <= 8'h00;
    end
  end

  // Prefix run length, measured on the output flag itself
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_len <= 5'h00;
    end else if (in_prefix_out) begin
      pre_len <= pre_len + 5'h01;
    end else begin
      pre_len <= 5'h00;
    end
  end

  a_beacon_long_cp: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE3]
    (state == OSF_EMIT && frame.beacon) |-> cp_len == 5'd16)
    else $error("beacon prefix not 1/8");
  a_preamble_long_cp: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE15]
    (state == OSF_EMIT && seg != SEG_HEADER_SYMBOL_FIRST && seg != SEG_HEADER_SYMBOL_SECOND && seg != SEG_PAY)
    |-> cp_len == 5'd16)
    else $error("preamble prefix not 1/8");
  a_cp_legal: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    state == OSF_EMIT |-> cp_len inside {5'd4, 5'd8, 5'd16})
    else $error("illegal prefix length");
  a_guard_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
    (state == OSF_FILL && !training && is_guard) |=> xform_wdata_out == '0)
    else $error("guard tone not zero");
  a_guard_edges: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE7]
    (state == OSF_FILL && bin > 7'd12 && bin < 7'd116 && bin != 7'd64)
    |-> !is_guard)
    else $error("guard inside band");
  a_fill_len: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE4]
    $rose(state == OSF_FILL) |-> (state == OSF_FILL) [*8] ##0 bin == 7'd7)
    else $error("fill count wrong");
  a_hdr_order: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE9]
    (seg == SEG_HEADER_SYMBOL_FIRST && $changed(seg)) |-> $past(seg) inside {SEG_LONG2, SEG_BURST})
    else $error("header not after preamble");
  a_burst_pick: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE12]
    (state == OSF_IDLE && frame_valid_in && frame_in.streaming &&
     !frame_in.first_of_stream) |=> seg == SEG_BURST)
    else $error("burst preamble not chosen");
  a_normal_pick: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE11]
    (state == OSF_IDLE && frame_valid_in && !frame_in.streaming) |=> seg == SEG_SHORT)
    else $error("normal preamble not chosen");
  a_prefix_tail: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE21]
    (state == OSF_EMIT && ecnt == 8'h00) |-> rd_addr == 7'(N_FFT) - 7'(cp_len))
    else $error("prefix not copied from tail");
  // Classifier band plan sums: guards checked on every loaded vector, data and pilots on header and payload vectors only
  a_tone_plan: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE6]
    ($rose(state == OSF_XFORM) && !training)
    |-> n_data_bins == 8'(N_DATA) && n_pilot_bins == 3'(N_PILOT))
    else $error("data or pilot tone count wrong");
  a_guard_count: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
    $rose(state == OSF_XFORM) |-> n_guard_bins == 5'(GUARD_LOW + 1 + GUARD_HIGH))
    else $error("guard tone count wrong");
  // Output side: a symbol is one unbroken run of prefix plus 128 samples
  a_sym_samples: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE1]
    $fell(sample_valid_out) |-> run_len inside {8'd132, 8'd136, 8'd144})
    else $error("symbol sample count wrong");
  a_prefix_run: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    $fell(in_prefix_out) |-> pre_len inside {5'd4, 5'd8, 5'd16})
    else $error("prefix run length wrong");
  a_preamble_run: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE15]
    ($fell(in_prefix_out) && seg_out < 3'h4) |-> pre_len == 5'd16)
    else $error("preamble prefix run not 1/8");
  a_take_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE8]
    $onehot0({data_take_out, pilot_take_out, train_take_out}))
    else $error("more than one tone source taken");
  a_long_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE14]
    (seg == SEG_LONG2 && $changed(seg)) |-> $past(seg) == SEG_LONG1)
    else $error("second long training not after first");
  a_burst_one: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE20]
    (state == OSF_EMIT && seg == SEG_BURST && ecnt == 8'(N_FFT - 1) + {3'h0, cp_len})
    |=> seg == SEG_HEADER_SYMBOL_FIRST)
    else $error("burst preamble not one symbol");
  a_end_with_sample: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE9]
    frame_end_out |-> sample_valid_out)
    else $error("frame end without sample");
  a_start_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE4]
    xform_start_out |=> !xform_start_out)
    else $error("transform start longer than one cycle");
  c_burst_frame: cover property (@(posedge clk_in) seg == SEG_BURST && state == OSF_EMIT);
  c_payload: cover property (@(posedge clk_in) seg == SEG_PAY && state == OSF_EMIT);
  c_short_cp: cover property (@(posedge clk_in) state == OSF_EMIT && cp_len == 5'd4);
  c_frame_end: cover property (@(posedge clk_in) frame_end_out);
endmodule

// [sim/osf_xform_model.sv]
// Transform engine stand-in: identity transform over the 128-entry memory
module osf_xform_model
  import osf_pkg::*;
(
  // Clock, reset and pacing
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  // Framer side
  input wire logic start_in,
  input wire logic we_in,
  input wire logic [6:0] addr_in,
  input wire osf_pkg::osf_sample_t wdata_in,
  output logic done_out,
  output osf_pkg::osf_sample_t rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  osf_sample_t mem [N_FFT];
  logic [5:0] left;
  // Identity keeps each bin visible at its own sample position
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
  // Read is combinational on the framer's registered address, one cycle behind it
  assign rdata_out = mem[addr_in];
  // Done after 3 or 40 cycles, so quick and slow engines are both seen
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= 6'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= (left == 6'h01);
      if (start_in) begin
        left <= slow_in ? 6'h28 : 6'h03;
      end else if (left != 6'h00) begin
        left <= left - 6'h01;
      end
    end
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the OFDM symbol framer
module tb_top
  import osf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, fvalid, slow, ready, dtake, ptake, ttake, start, we, done, svalid, pre, fend;
  osf_frame_t frame;
  osf_sample_t wdata, xrd, smp;
  osf_sample_t dtone = 32'h0d000d00;
  osf_sample_t ptone = 32'h0b000b00;
  osf_sample_t ttone = 32'h0c000c00;
  logic [2:0] seg;
  logic [6:0] addr;
  int n_errors, n_tests, n_data, n_pilot, n_train;
  osf_sample_t q_s[$];
  logic q_p[$];
  logic [2:0] q_g[$];
  osf_framer u_osf_framer (.clk_in(clk), .rst_n_in(rst_n), .frame_valid_in(fvalid),
    .frame_in(frame), .frame_ready_out(ready), .data_tone_in(dtone), .pilot_tone_in(ptone),
    .train_tone_in(ttone), .data_take_out(dtake), .pilot_take_out(ptake),
    .train_take_out(ttake), .seg_out(seg), .xform_start_out(start), .xform_we_out(we),
    .xform_addr_out(addr), .xform_wdata_out(wdata), .xform_done_in(done),
    .xform_rdata_in(xrd), .sample_valid_out(svalid), .sample_out(smp),
    .in_prefix_out(pre), .frame_end_out(fend));
  osf_xform_model u_osf_xform_model (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
    .start_in(start), .we_in(we), .addr_in(addr), .wdata_in(wdata), .done_out(done),
    .rdata_out(xrd));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Tone suppliers advance on take; top byte marks the tone kind
  always @(posedge clk) begin
    if (dtake === 1'b1) dtone.re[7:0] <= dtone.re[7:0] + 8'h01;
    if (ptake === 1'b1) ptone.im[7:0] <= ptone.im[7:0] + 8'h01;
    if (ttake === 1'b1) ttone.im[7:0] <= ttone.im[7:0] + 8'h01;
  end
  // Sample monitor
  always @(posedge clk) begin
    if (svalid === 1'b1) begin
      q_s.push_back(smp);
      q_p.push_back(pre);
      q_g.push_back(seg);
    end
    if (dtake === 1'b1) n_data++;
    if (ptake === 1'b1) n_pilot++;
    if (ttake === 1'b1) n_train++;
  end
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check_eq(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Expected kind of bin j: guard zero, pilot 0b, data 0d
  function automatic logic [7:0] kind(int j);
    logic [6:0] b;
    b = j[6:0];
    if (j < GUARD_LOW || j == DC_BIN || j >= N_FFT - GUARD_HIGH) return 8'h00;
    if (b == PILOT_BIN0 || b == PILOT_BIN1 || b == PILOT_BIN2 || b == PILOT_BIN3) return 8'h0b;
    return 8'h0d;
  endfunction
  // ****************************************
  // Frame request and stream check
  // ****************************************
  task automatic run(logic [1:0] m, logic b, logic st, logic f, logic [11:0] np, bit nrm, int cp);
    logic [2:0] segs[$];
    int k, n, j, i;
    i = 0;
    while (ready !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    check_eq("ready", 32'h1, ready);
    q_s.delete();
    q_p.delete();
    q_g.delete();
    n_data = 0;
    n_pilot = 0;
    n_train = 0;
    fvalid <= 1'b1;
    frame <= '{m, b, st, f, np};
    @(posedge clk);
    fvalid <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (fend !== 1'b1 && i < 20000);
    @(posedge clk);
    if (nrm) segs = '{3'h0, 3'h1, 3'h2};
    else segs = '{3'h3};
    segs.push_back(3'h4);
    segs.push_back(3'h5);
    repeat (np) segs.push_back(3'h6);
    k = 0;
    foreach (segs[s]) begin
      n = 0;
      while (k + n < q_p.size() && q_p[k + n] === 1'b1) n++;
      check_eq("prefix", (segs[s] > 3'h3) ? cp : CP_LEN_8, n);
      check_eq("segment", segs[s], q_g[k]);
      for (j = 0; j < n; j++) check_eq("copy", q_s[k + N_FFT + j], q_s[k + j]);
      for (j = 0; j < N_FFT && segs[s] > 3'h3; j++) begin
        smp_kind(kind(j), q_s[k + n + j]);
      end
      k += n + N_FFT;
    end
    check_eq("samples", k, q_s.size());
    check_eq("data takes", N_DATA * (np + 2), n_data);
    check_eq("pilot takes", N_PILOT * (np + 2), n_pilot);
    check_eq("train takes", N_FFT * (nrm ? 3 : 1), n_train);
  endtask
  task automatic smp_kind(logic [7:0] exp, osf_sample_t v);
    check_eq("tone kind", exp, (v === '0) ? 8'h00 : v.re[15:8]);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_normal();
    run(CP_MODE_32, 1'b0, 1'b0, 1'b0, 12'h001, 1'b1, CP_LEN_32);
  endtask
  task automatic t_stream_modes();
    int cps[4] = '{CP_LEN_32, CP_LEN_16, CP_LEN_8, CP_LEN_32};
    for (int m = 0; m < 4; m++) begin
      slow <= m[0];
      run(m[1:0], 1'b0, 1'b1, 1'b0, 12'h001, 1'b0, cps[m]);
    end
    slow <= 1'b0;
  endtask
  task automatic t_beacon();
    run(CP_MODE_32, 1'b1, 1'b0, 1'b0, 12'h002, 1'b1, CP_LEN_8);
  endtask
  task automatic t_stream_first();
    run(CP_MODE_16, 1'b0, 1'b1, 1'b1, 12'h000, 1'b1, CP_LEN_16);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    fvalid = 1'b0;
    frame = '0;
    slow = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_normal();
    t_stream_modes();
    t_beacon();
    t_stream_first();
    complete_run();
  end
  // Watchdog at 80000 cycles, well beyond the expected ten thousand or so
  initial begin
    #8000000;
    n_errors++;
    complete_run();
  end
endmodule
